// ===== hdl/lsbtc_ctrl.sv
// Top of the LCD supply, bias and temperature control.
// Assumes the command decoder delivers one-cycle write strobes on mclk_in;
// the sensor step count arrives from the analog domain and is synchronised here.
`timescale 1ns/1ns
module lsbtc_ctrl
  import lsbtc_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DFLT
) (
  input  wire logic            mclk_in,                // 10 MHz system clock.
  input  wire logic            rst_n_in,               // Synchronous reset, active low.
  input  wire logic            bias_wr_in,             // Bias select write strobe.
  input  wire lsbtc_bias_t     bias_in,                // Bias select write data.
  input  wire logic            cfg_wr_in,              // Supply config write strobe.
  input  wire lsbtc_cfg_t      cfg_in,                 // Supply config write data.
  input  wire logic            pump_wr_in,             // Pump factor write strobe.
  input  wire logic [2:0]      pump_factor_in,         // Pump factor write data.
  input  wire logic            vop_wr_in,              // Voltage code write strobe.
  input  wire logic [6:0]      vop_in,                 // Voltage code write data.
  input  wire logic            measure_wr_in,          // Write of 1 to measure_start.
  input  wire logic [7:0]      temp_delta_in,          // Sensor steps from 27 C, signed.
  output logic [3:0]           bias_n_out,             // Bias n, two's complement.
  output logic [2:0]           pump_factor_out,        // Stored pump_factor field.
  output logic [3:0]           pump_mult_out,          // Multiplication factor.
  output logic                 pump_run_out,           // Charge pump running.
  output lsbtc_vlcd_src_t      vlcd_src_out,           // Source of pumped_output.
  output logic [6:0]           lcd_voltage_code_out,   // Stored lcd_voltage_code.
  output logic                 voltage_range_out,      // Stored voltage_range_select.
  output logic [15:0]          vlcd_target_mv_out,     // Target voltage in mV.
  output logic [1:0]           temp_coefficient_out,   // Stored temp_coefficient.
  output logic                 lcd_ground_out,         // LCD outputs held at ground.
  output logic                 osc_run_out,            // Oscillator running.
  output logic                 measure_start_out,      // measure_start bit.
  output logic                 measure_busy_out,       // Measurement in progress.
  output logic [7:0]           temperature_status_out  // Temperature status register.
);

  // Refuses a frame too short for the measurement sequencer.
  if (FRAME_CYCLES < 2) begin
    $error("FRAME_CYCLES must be at least 2");
  end

  lsbtc_bias_t bias;
  lsbtc_cfg_t  cfg;
  logic [7:0]  delta_meta;
  logic [7:0]  delta_sync;
  logic        meas_done;
  logic        frame_tick;

  // Settings applied next cycle, so outputs follow a write by one edge.
  wire lsbtc_bias_t next_bias   = bias_wr_in ? bias_in : bias;
  wire lsbtc_cfg_t  next_cfg    = cfg_wr_in ? cfg_in : cfg;
  wire logic [6:0]  next_vop    = vop_wr_in ? vop_in : lcd_voltage_code_out;
  wire logic [2:0]  next_factor = pump_wr_in ? pump_factor_in : pump_factor_out;

  // The pump follows the source table: a running pump wins over direct drive.
  wire logic        next_pump_run = next_cfg.pump_enable && !next_cfg.power_down &&
                                    !next_cfg.display_off;
  wire lsbtc_vlcd_src_t next_src  = next_pump_run ? VL_PUMPED :
                                    (next_cfg.direct_drive_select ? VL_DIRECT : VL_HIZ);

  wire logic        start_ok      = measure_wr_in && !cfg.power_down;
  wire logic [7:0]  next_temp     = lsbtc_temp_code(delta_sync);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      bias                 <= BIAS_RESET;
      cfg                  <= CFG_RESET;
      lcd_voltage_code_out <= VOP_RESET;
      pump_factor_out      <= PUMP_FACTOR_RESET;
    end else begin
      bias                 <= next_bias;
      cfg                  <= next_cfg;
      lcd_voltage_code_out <= next_vop;
      pump_factor_out      <= next_factor;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      bias_n_out           <= BIAS_N_MAX;
      pump_mult_out        <= PUMP_FACTOR_BASE;
      pump_run_out         <= 1'b0;
      vlcd_src_out         <= VL_HIZ;
      voltage_range_out    <= 1'b0;
      vlcd_target_mv_out   <= VLCD_BASE_LOW_MV;
      temp_coefficient_out <= 2'h0;
      lcd_ground_out       <= 1'b1;
    end else begin
      bias_n_out           <= lsbtc_bias_n(next_bias);
      pump_mult_out        <= 4'(PUMP_FACTOR_BASE + {1'b0, next_factor});
      pump_run_out         <= next_pump_run;
      vlcd_src_out         <= next_src;
      voltage_range_out    <= next_cfg.voltage_range_select;
      vlcd_target_mv_out   <= lsbtc_vlcd_mv(next_cfg.voltage_range_select, next_vop);
      temp_coefficient_out <= next_cfg.temp_coefficient;
      lcd_ground_out       <= next_cfg.power_down || next_cfg.display_off;
    end
  end

  // The sensor holds its result steady around the end of a measurement.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      delta_meta <= 8'h00;
      delta_sync <= 8'h00;
    end else begin
      delta_meta <= temp_delta_in;
      delta_sync <= delta_meta;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      temperature_status_out <= TEMP_STATUS_RESET;
    end else if (meas_done) begin
      temperature_status_out <= next_temp;
    end else if (start_ok && !measure_busy_out) begin
      temperature_status_out <= 8'h00;
    end
  end

  lsbtc_meas_seq #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_meas_seq (
    .mclk_in           (mclk_in),
    .rst_n_in          (rst_n_in),
    .power_down_in     (cfg.power_down),
    .start_wr_in       (measure_wr_in),
    .measure_start_out (measure_start_out),
    .busy_out          (measure_busy_out),
    .done_out          (meas_done),
    .osc_run_out       (osc_run_out),
    .frame_tick_out    (frame_tick)
  );

  default clocking cb @(posedge mclk_in);
  endclocking

  default disable iff (!rst_n_in);

  sequence s_start_bit_high;
    measure_start_out [*5];
  endsequence

  sequence s_start_bit_clears;
    s_start_bit_high ##1 !measure_start_out;
  endsequence

  AST_BIAS_RATIO: assert property (
    !$past(next_bias.half_bias_select) |->
      bias_n_out == BIAS_N_MAX - {1'b0, $past(next_bias.bias_ratio_select)})
    else $error("bias n does not follow the ratio select");

  AST_HALF_BIAS: assert property (
    bias_wr_in && bias_in.half_bias_select |=> bias_n_out == 4'hE)
    else $error("half bias does not give n of minus two");

  AST_PUMP_RESET: assert property (
    $rose(rst_n_in) |-> pump_mult_out == 4'h2 && pump_factor_out == 3'h0)
    else $error("pump factor is not two after reset");

  AST_PUMP_WRITE: assert property (
    pump_wr_in |=> pump_mult_out == 4'h2 + {1'b0, $past(pump_factor_in)})
    else $error("pump factor write not applied on the next cycle");

  AST_PUMP_START: assert property (
    cfg.power_down && cfg_wr_in && !cfg_in.power_down && cfg_in.pump_enable &&
    !cfg_in.display_off |=> pump_run_out && vlcd_src_out == VL_PUMPED ##1 pump_run_out)
    else $error("pump did not start when power down was cleared");

  AST_DIRECT_DRIVE: assert property (
    !pump_run_out && cfg.direct_drive_select && $stable(cfg) |-> vlcd_src_out == VL_DIRECT)
    else $error("direct drive not selected");

  AST_SM_SELF_CLEAR: assert property (
    $rose(measure_start_out) |-> s_start_bit_clears)
    else $error("measure_start did not clear after five cycles");

  AST_STATUS_ZERO: assert property (
    measure_busy_out && !$past(meas_done) |-> temperature_status_out == 8'h00)
    else $error("status not zero during a measurement");

  AST_STATUS_LOAD: assert property (
    meas_done |=> temperature_status_out == lsbtc_temp_code($past(delta_sync)) &&
                  temperature_status_out != 8'h00)
    else $error("status not loaded with a non-zero code");

  AST_NO_MEAS_IN_PD: assert property (
    cfg.power_down |=> !measure_busy_out ##1 !meas_done)
    else $error("measurement runs in power down");

  AST_PD_IGNORE: assert property (
    measure_wr_in && cfg.power_down && !meas_done |=>
      $stable(temperature_status_out) && !$rose(measure_start_out))
    else $error("start accepted during power down");

  AST_PD_GROUND: assert property (
    cfg.power_down |-> lcd_ground_out ##1 !osc_run_out && !frame_tick)
    else $error("LCD outputs or timing active in power down");

  AST_VLCD_TARGET: assert property (
    $stable(lcd_voltage_code_out) && $stable(voltage_range_out) |->
      vlcd_target_mv_out == (voltage_range_out ? 16'h27E7 : 16'h1194) +
                            16'({9'h000, lcd_voltage_code_out} * 16'h002D))
    else $error("voltage target does not match code and range");

  AST_TEMP_MIDPOINT: assert property (
    meas_done && delta_sync == 8'h00 |=> temperature_status_out == 8'h80)
    else $error("code at 27 C is not 128");

endmodule

// ===== hdl/lsbtc_pkg.sv
// Constants, carriers and decode helpers of the LCD supply, bias and temperature control.
// Assumes one 10 MHz clock and an external command decoder on the same clock.
// Operation
// - With half bias off, bias code 000 gives n of 7, down to 111 giving 0.
// - With half bias on, n is minus two whatever the bias code holds.
// - Reset sets the charge-pump multiplication factor to two.
// - Any other multiplication factor comes from the three-bit pump_factor field.
// - Clearing power_down with pump_enable set and display_off clear starts the pump at the programmed factor.
// - Each finished measurement writes an eight-bit temperature_code into the status register.
// - Writing measure_start begins a measurement; the bit clears itself after five clocks.
// - Two warm-up frames, then measure from next frame start for two frames.
// - No temperature measurement runs while power_down is set.
// - Status reads zero during a measurement, then the new non-zero code.
// - Temperature code is offset binary, 128 at 27 degrees C.
// - Pumped voltage target rises linearly with the seven-bit lcd_voltage_code.
// - Range select gives base 4.500 V or 10.215 V, step 0.045 V per code.
// - Power down stops oscillator and timing, grounds LCD outputs, keeps registers.
// - Direct drive, with the charge pump not running, connects the pumped output straight to the pump supply.
package lsbtc_pkg;

  localparam int unsigned        SM_CLEAR_CYCLES    = 5;
  localparam int unsigned        WARMUP_FRAMES      = 2;
  localparam int unsigned        MEAS_FRAMES        = 2;
  localparam int unsigned        FRAME_CLK_DIV      = 1088;
  localparam int unsigned        PREDIV_RESET       = 4;
  localparam int unsigned        FRAME_CYCLES_DFLT  = FRAME_CLK_DIV * PREDIV_RESET;
  localparam logic [2:0]         PUMP_FACTOR_RESET  = 3'h0;
  localparam logic [3:0]         PUMP_FACTOR_BASE   = 4'h2;
  localparam logic [3:0]         BIAS_N_MAX         = 4'h7;
  localparam logic [3:0]         BIAS_N_HALF        = 4'hE;
  localparam logic [6:0]         VOP_RESET          = 7'h00;
  localparam logic [15:0]        VLCD_BASE_LOW_MV   = 16'h1194;
  localparam logic [15:0]        VLCD_BASE_HIGH_MV  = 16'h27E7;
  localparam logic [15:0]        VLCD_STEP_MV       = 16'h002D;
  localparam logic [7:0]         TEMP_CODE_AT_27C   = 8'h80;
  localparam logic [7:0]         TEMP_CODE_MIN      = 8'h01;
  localparam logic [7:0]         TEMP_STATUS_RESET  = 8'h00;

  typedef struct packed {
    logic       half_bias_select;
    logic [2:0] bias_ratio_select;
  } lsbtc_bias_t;

  typedef struct packed {
    logic       power_down;
    logic       direct_drive_select;
    logic       pump_enable;
    logic       voltage_range_select;
    logic       display_off;
    logic [1:0] temp_coefficient;
  } lsbtc_cfg_t;

  localparam lsbtc_bias_t BIAS_RESET = '{half_bias_select: 1'b0, bias_ratio_select: 3'h0};
  localparam lsbtc_cfg_t  CFG_RESET  = '{power_down: 1'b1, direct_drive_select: 1'b0,
                                         pump_enable: 1'b0, voltage_range_select: 1'b0,
                                         display_off: 1'b0, temp_coefficient: 2'h0};

  typedef enum logic [1:0] {VL_HIZ, VL_DIRECT, VL_PUMPED} lsbtc_vlcd_src_t;

  typedef enum logic [1:0] {MS_IDLE, MS_WARMUP, MS_ALIGN, MS_MEASURE} lsbtc_ms_state_t;

  // Two's complement n of the selected bias system.
  function automatic logic [3:0] lsbtc_bias_n(input lsbtc_bias_t b);
    return b.half_bias_select ? BIAS_N_HALF : BIAS_N_MAX - {1'b0, b.bias_ratio_select};
  endfunction

  // Target pumped voltage in millivolts at the cut-point temperature.
  function automatic logic [15:0] lsbtc_vlcd_mv(input logic range, input logic [6:0] code);
    logic [15:0] base;
    base = range ? VLCD_BASE_HIGH_MV : VLCD_BASE_LOW_MV;
    return 16'(base + 16'({9'h000, code} * VLCD_STEP_MV));
  endfunction

  // Offset-binary code from a signed step count relative to 27 degrees C, never zero.
  function automatic logic [7:0] lsbtc_temp_code(input logic [7:0] delta);
    logic [7:0] code;
    code = 8'(TEMP_CODE_AT_27C + delta);
    return (code == 8'h00) ? TEMP_CODE_MIN : code;
  endfunction

endpackage

// ===== hdl/lsbtc_meas_seq.sv
// Frame timing and temperature measurement sequencer.
// Assumes power_down and the start strobe come from logic on the same clock.
`timescale 1ns/1ns
module lsbtc_meas_seq
  import lsbtc_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DFLT
) (
  input  wire logic mclk_in,           // System clock.
  input  wire logic rst_n_in,          // Synchronous reset, active low.
  input  wire logic power_down_in,     // Power-down setting.
  input  wire logic start_wr_in,       // Host write of 1 to measure_start.
  output logic      measure_start_out, // Self-clearing start bit.
  output logic      busy_out,          // Measurement sequence in progress.
  output logic      done_out,          // One-cycle pulse at measurement end.
  output logic      osc_run_out,       // Oscillator and timing running.
  output logic      frame_tick_out     // One-cycle pulse at each frame start.
);

  localparam int unsigned FW = (FRAME_CYCLES > 2) ? $clog2(FRAME_CYCLES) : 1;

  // Refuses a frame too short for the tick and counter logic.
  if (FRAME_CYCLES < 2) begin
    $error("FRAME_CYCLES must be at least 2");
  end

  lsbtc_ms_state_t state;
  lsbtc_ms_state_t next_state;
  logic [FW-1:0]   frame_cnt;
  logic [1:0]      frames;
  logic [1:0]      next_frames;
  logic            next_done;
  logic [2:0]      sm_cnt;

  wire logic       frame_last = (frame_cnt == FW'(FRAME_CYCLES - 1));
  wire logic       start_ok   = start_wr_in && !power_down_in;
  wire logic       last_warm  = (frames == 2'(WARMUP_FRAMES - 1));
  wire logic       last_meas  = (frames == 2'(MEAS_FRAMES - 1));

  always_comb begin
    next_state  = state;
    next_frames = frames;
    next_done   = 1'b0;
    case (state)
      MS_IDLE: begin
        if (start_ok) begin
          next_state  = MS_WARMUP;
          next_frames = 2'h0;
        end
      end
      MS_WARMUP: begin
        if (frame_tick_out) begin
          next_frames = 2'(frames + 2'h1);
          if (last_warm) next_state = MS_ALIGN;
        end
      end
      MS_ALIGN: begin
        if (frame_tick_out) begin
          next_state  = MS_MEASURE;
          next_frames = 2'h0;
        end
      end
      MS_MEASURE: begin
        if (frame_tick_out) begin
          next_frames = 2'(frames + 2'h1);
          if (last_meas) begin
            next_state = MS_IDLE;
            next_done  = 1'b1;
          end
        end
      end
      default: next_state = MS_IDLE;
    endcase
    if (power_down_in) begin
      next_state = MS_IDLE;
      next_done  = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state          <= MS_IDLE;
      frames         <= 2'h0;
      done_out       <= 1'b0;
      busy_out       <= 1'b0;
      frame_cnt      <= '0;
      frame_tick_out <= 1'b0;
      osc_run_out    <= 1'b0;
    end else begin
      state          <= next_state;
      frames         <= next_frames;
      done_out       <= next_done;
      busy_out       <= (next_state != MS_IDLE);
      osc_run_out    <= !power_down_in;
      frame_cnt      <= (power_down_in || frame_last) ? '0 : FW'(frame_cnt + 1'b1);
      frame_tick_out <= !power_down_in && frame_last;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      measure_start_out <= 1'b0;
      sm_cnt            <= 3'h0;
    end else if (start_ok) begin
      measure_start_out <= 1'b1;
      sm_cnt            <= 3'h0;
    end else if (measure_start_out) begin
      sm_cnt <= 3'(sm_cnt + 3'h1);
      if (sm_cnt == 3'(SM_CLEAR_CYCLES - 1)) measure_start_out <= 1'b0;
    end
  end

  sequence s_align_to_measure;
    (state == MS_ALIGN) && frame_tick_out ##1 (state == MS_MEASURE);
  endsequence

  AST_MEASURE_ON_FRAME: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == MS_ALIGN) && !frame_tick_out && !power_down_in |=> (state == MS_ALIGN))
    else $error("measurement left alignment without a frame start");

  AST_DONE_AFTER_FRAMES: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_align_to_measure |-> !done_out [*2])
    else $error("measurement finished too early");

endmodule

// ===== bench/lsbtc_host_model.sv
// Host side model: turns register writes into one-cycle decoder strobes.
// Assumes its tasks are entered at a falling edge of mclk_in.
`timescale 1ns/1ns
module lsbtc_host_model
  import lsbtc_pkg::*;
(
  input  wire logic  mclk_in,         // System clock.
  output lsbtc_bias_t bias_out,       // Bias select data.
  output logic        bias_wr_out,    // Bias select strobe.
  output lsbtc_cfg_t  cfg_out,        // Supply config data.
  output logic        cfg_wr_out,     // Supply config strobe.
  output logic [2:0]  pump_factor_out, // Pump factor data.
  output logic        pump_wr_out,    // Pump factor strobe.
  output logic [6:0]  vop_out,        // Voltage code data.
  output logic        vop_wr_out,     // Voltage code strobe.
  output logic        measure_wr_out  // Start request strobe.
);
  initial begin
    {bias_wr_out, cfg_wr_out, pump_wr_out, vop_wr_out, measure_wr_out} = 5'h00;
    bias_out = BIAS_RESET;
    cfg_out = CFG_RESET;
    pump_factor_out = 3'h0;
    vop_out = 7'h00;
  end

  // One idle edge follows every strobe, so no strobe is set twice in a time step.
  task automatic end_wr;
    @(negedge mclk_in);
    {bias_wr_out, cfg_wr_out, pump_wr_out, vop_wr_out, measure_wr_out} = 5'h00;
    @(negedge mclk_in);
  endtask

  task automatic wr_bias(input lsbtc_bias_t b);
    bias_out = b;
    bias_wr_out = 1'b1;
    end_wr();
  endtask

  task automatic wr_cfg(input lsbtc_cfg_t c);
    cfg_out = c;
    cfg_wr_out = 1'b1;
    end_wr();
  endtask

  task automatic wr_pump(input logic [2:0] f);
    pump_factor_out = f;
    pump_wr_out = 1'b1;
    end_wr();
  endtask

  task automatic wr_vop(input logic [6:0] v);
    vop_out = v;
    vop_wr_out = 1'b1;
    end_wr();
  endtask

  task automatic start_meas;
    measure_wr_out = 1'b1;
    end_wr();
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench of the LCD supply, bias and temperature control.
// Assumes the host model drives the strobes; expectations go through queues.
`timescale 1ns/1ns
module tb_top;
  import lsbtc_pkg::*;
  localparam int unsigned FRAME = 8;
  logic mclk_in, rst_n_in, bias_wr, cfg_wr, pump_wr, vop_wr, meas_wr;
  logic pump_run, lcd_ground, osc_run, meas_start, busy, v_range;
  lsbtc_bias_t bias;
  lsbtc_cfg_t cfg, cur_cfg;
  lsbtc_vlcd_src_t src;
  logic [2:0] pump_f, pump_fo;
  logic [3:0] bias_n, pump_mult, seen;
  logic [6:0] lcd_voltage_code, vop_o, cur_vop;
  logic [7:0] temp_delta, status, first_read;
  logic [15:0] target;
  logic [1:0] tc;
  logic [31:0] q_bias[$], q_cfg[$], q_pump[$], q_vop[$], q_sm[$], q_temp[$];
  int n_fail = 0, tests_run = 0, cycles = 0, sm_len = 0, busy_len = 0, pend = 0;
  logic rst_q = 1'b0, busy_q = 1'b0, len_ok = 1'b0;

  lsbtc_host_model i_host (.mclk_in(mclk_in), .bias_out(bias), .bias_wr_out(bias_wr),
    .cfg_out(cfg), .cfg_wr_out(cfg_wr), .pump_factor_out(pump_f), .pump_wr_out(pump_wr),
    .vop_out(lcd_voltage_code), .vop_wr_out(vop_wr), .measure_wr_out(meas_wr));

  lsbtc_ctrl #(.FRAME_CYCLES(FRAME)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .bias_wr_in(bias_wr), .bias_in(bias), .cfg_wr_in(cfg_wr), .cfg_in(cfg),
    .pump_wr_in(pump_wr), .pump_factor_in(pump_f), .vop_wr_in(vop_wr), .vop_in(lcd_voltage_code),
    .measure_wr_in(meas_wr), .temp_delta_in(temp_delta), .bias_n_out(bias_n),
    .pump_factor_out(pump_fo), .pump_mult_out(pump_mult), .pump_run_out(pump_run),
    .vlcd_src_out(src), .lcd_voltage_code_out(vop_o), .voltage_range_out(v_range),
    .vlcd_target_mv_out(target), .temp_coefficient_out(tc), .lcd_ground_out(lcd_ground),
    .osc_run_out(osc_run), .measure_start_out(meas_start), .measure_busy_out(busy),
    .temperature_status_out(status));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  function automatic logic [15:0] exp_mv(input logic r, input logic [6:0] v);
    return 16'((r ? 16'h27E7 : 16'h1194) + 16'h002D * {9'h000, v});
  endfunction

  function automatic logic [31:0] exp_cfg(input lsbtc_cfg_t c, input logic [6:0] v);
    logic pumped;
    pumped = c.pump_enable & ~c.power_down & ~c.display_off;
    return {9'h000, pumped, pumped ? 2'h2 : {1'b0, c.direct_drive_select},
            c.power_down | c.display_off, c.voltage_range_select, c.temp_coefficient,
            exp_mv(c.voltage_range_select, v)};
  endfunction

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A result with no note left is compared against its own inverse, so it fails.
  task automatic take(ref logic [31:0] q[$], input logic [31:0] got);
    compare(got, (q.size() != 0) ? q.pop_front() : ~got);
  endtask

  task automatic do_bias(input lsbtc_bias_t b);
    q_bias.push_back(b.half_bias_select ? 32'h0000000E : 32'(4'h7 - {1'b0, b.bias_ratio_select}));
    i_host.wr_bias(b);
  endtask

  task automatic do_cfg(input lsbtc_cfg_t c);
    // The oscillator flag still shows the setting from before this write.
    q_cfg.push_back(exp_cfg(c, cur_vop) | {!cur_cfg.power_down, 31'h00000000});
    cur_cfg = c;
    i_host.wr_cfg(c);
  endtask

  task automatic do_pump(input logic [2:0] f);
    q_pump.push_back({25'h0000000, f, 4'(4'h2 + {1'b0, f})});
    i_host.wr_pump(f);
  endtask

  task automatic do_vop(input logic [6:0] v);
    q_vop.push_back({9'h000, v, exp_mv(cur_cfg.voltage_range_select, v)});
    cur_vop = v;
    i_host.wr_vop(v);
  endtask

  task automatic do_meas(input logic [7:0] d, input bit abort);
    logic [7:0] code;
    lsbtc_cfg_t c;
    temp_delta = d;
    code = 8'(8'h80 + d);
    if (code == 8'h00)
      code = 8'h01;
    q_sm.push_back(32'h00000005);
    q_temp.push_back(32'h00000000);
    q_temp.push_back(abort ? 32'h00000000 : {1'b1, 23'h000000, code});
    i_host.start_meas();
    c = cur_cfg;
    if (abort) begin
      repeat (10) @(negedge mclk_in);
      c.power_down = 1'b1;
      do_cfg(c);
      c.power_down = 1'b0;
      do_cfg(c);
    end
    for (int i = 0; i < 100 && (busy !== 1'b0 || meas_start !== 1'b0); i++)
      @(negedge mclk_in);
    repeat (2) @(negedge mclk_in);
  endtask

  always @(posedge mclk_in) begin
    seen <= {4{rst_n_in}} & ({4{~rst_q}} | {bias_wr, cfg_wr, pump_wr, vop_wr});
    rst_q <= rst_n_in;
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  always @(negedge mclk_in) begin
    if (seen[3]) take(q_bias, {28'h0000000, bias_n});
    if (seen[2]) take(q_cfg, {osc_run, 8'h00, pump_run, src, lcd_ground, v_range, tc, target});
    if (seen[1]) take(q_pump, {25'h0000000, pump_fo, pump_mult});
    if (seen[0]) take(q_vop, {9'h000, vop_o, target});
    if (meas_start === 1'b1) sm_len++;
    else if (sm_len != 0) begin
      take(q_sm, 32'(sm_len));
      sm_len = 0;
    end
    if (busy === 1'b1 && !busy_q) take(q_temp, {24'h000000, status});
    if (busy === 1'b1) busy_len++;
    else if (busy_q) begin
      // Status is loaded one edge after busy falls, so it is read on the two cycles after.
      len_ok = busy_len >= 4 * FRAME && busy_len <= 5 * FRAME + 3;
      busy_len = 0;
      pend = 1;
    end else if (pend == 1) begin
      first_read = status;
      pend = 2;
    end else if (pend == 2) begin
      take(q_temp, {len_ok && status === first_read, 23'h0, status});
      pend = 0;
    end
    busy_q = (busy === 1'b1);
  end

  initial begin
    lsbtc_cfg_t c;
    void'($urandom(7984));
    rst_n_in = 1'b0;
    temp_delta = 8'h00;
    cur_cfg = CFG_RESET;
    cur_vop = 7'h00;
    q_bias.push_back(32'h00000007);
    q_cfg.push_back(exp_cfg(CFG_RESET, 7'h00));
    q_pump.push_back(32'h00000002);
    q_vop.push_back({16'h0000, exp_mv(1'b0, 7'h00)});
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    @(negedge mclk_in);
    for (int i = 0; i < 16; i++)
      do_bias(lsbtc_bias_t'(i[3:0]));
    do_bias(lsbtc_bias_t'(4'h2));
    c = cur_cfg;
    c.direct_drive_select = 1'b1;
    c.temp_coefficient = 2'h1;
    do_cfg(c);
    do_pump(3'h0);
    do_vop(7'($urandom));
    c.voltage_range_select = 1'b1;
    c.pump_enable = 1'b1;
    do_cfg(c);
    c.power_down = 1'b0;
    do_cfg(c);
    for (int f = 1; f < 8; f++)
      do_pump(3'(f));
    for (int i = 0; i < 16; i++) begin
      {c.direct_drive_select, c.pump_enable, c.power_down, c.display_off} = i[3:0];
      do_cfg(c);
    end
    for (int i = 0; i < 6; i++) begin
      c.voltage_range_select = i[0];
      do_cfg(c);
      do_vop((i == 5) ? 7'h7F : 7'($urandom));
    end
    {c.pump_enable, c.power_down, c.display_off} = 3'h4;
    do_cfg(c);
    do_meas(8'($urandom), 1'b0);
    do_meas(8'h00, 1'b0);
    do_meas(8'h80, 1'b0);
    do_meas(8'($urandom), 1'b1);
    c.power_down = 1'b1;
    do_cfg(c);
    i_host.start_meas();
    repeat (60) @(negedge mclk_in);
    c.power_down = 1'b0;
    do_cfg(c);
    do_meas(8'($urandom), 1'b0);
    repeat (4) @(negedge mclk_in);
    compare(32'(q_bias.size() + q_cfg.size() + q_pump.size() + q_vop.size()
                + q_sm.size() + q_temp.size()), 32'h00000000);
    print_verdict();
  end
endmodule
